// ### design/vqctl_top.v
// Control and status pin logic around an adaptive video cable equalizer
`timescale 1ns/1ps
`include "vqctl_consts.vh"

// Notes on behaviour
// - Color pin: low monochrome, high color
// - Undriven color pin reports detected colorburst
// - Driven color pin forces equalizer color mode
// - Indicator pins default to outputs when undriven
// - Polarity pin: low nominal, high inverted
// - Undriven polarity pin reports detected polarity
// - Driven polarity pin sets video inversion
// - Stand-alone polarity pin pulse restarts acquisition
// - Lock low until equalized and settled
// - Freeze low updates, high holds equalizer
// - Bypass input low equalizes, high disables
module vqctl_top #(
  parameter PULSE_MAX_CYC = `VQ_PULSE_MAX_US * `VQ_CLK_MHZ,
  parameter SETTLE_CYC    = `VQ_SETTLE_TIME_US * `VQ_CLK_MHZ,
  parameter CW            = 17
) (
  input  wire          mclk,
  input  wire          arst_n,
  // Color indicator/override pin
  input  wire          color_in,
  output reg           color_out_q,
  output reg           color_oe_q,
  // Polarity indicator/override pin
  input  wire          invert_in,
  output reg           invert_out_q,
  output reg           invert_oe_q,
  // Lock indicator and freeze input
  output reg           locked_q,
  input  wire          freeze_in,
  // Equalizer bypass control pin
  input  wire          equalizer_bypass_ctl,
  // Serial interface enable; low means stand-alone operation
  input  wire          serial_select,
  // Status from the analog equalizer
  input  wire          burst_det,
  input  wire          pol_det,
  input  wire          sig_present,
  input  wire          eq_settled,
  // Controls to the analog equalizer
  output reg           eq_update_en_q,
  output reg           eq_restart_q,
  output reg           eq_bypass_q,
  output reg           color_mode_q,
  output reg           video_invert_q,
  // Override status
  output reg           color_ovr_q,
  output reg           invert_ovr_q
);

  // Saturating increment used by both counters
  function [CW-1:0] vq_inc;
    input [CW-1:0] v;
    begin
      if (&v) begin
        vq_inc = v;
      end else begin
        vq_inc = v + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // Synchronised pin and analog status inputs
  wire [`VQ_SB_WIDTH-1:0] raw_in;
  wire [`VQ_SB_WIDTH-1:0] syn;

  assign raw_in = {eq_settled, sig_present, pol_det, burst_det, serial_select,
                   equalizer_bypass_ctl, freeze_in, invert_in, color_in};

  vqctl_sync #(
    .W (`VQ_SB_WIDTH)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (raw_in),
    .q      (syn)
  );

  // Named views of the synchronised vector
  wire color_s   = syn[`VQ_SB_COLOR];
  wire invert_s  = syn[`VQ_SB_INVERT];
  wire freeze_s  = syn[`VQ_SB_FREEZE];
  wire bypass_s  = syn[`VQ_SB_BYPASS];
  wire sersel_s  = syn[`VQ_SB_SERSEL];
  wire burst_s   = syn[`VQ_SB_BURST];
  wire poldet_s  = syn[`VQ_SB_POLDET];
  wire sigpres_s = syn[`VQ_SB_SIGPRES];
  wire settled_s = syn[`VQ_SB_SETTLED];

  // Delay lines of our own drive, aligned with the synchroniser latency
  reg  [1:0]    color_drv_q;           // Color drive history
  reg  [1:0]    invert_drv_q;          // Polarity drive history
  // Override pulse width counter on the polarity pin
  reg  [CW-1:0] pulse_cnt_q;
  reg  [CW-1:0] pulse_cnt_d;
  // Equalizer state and settle counter
  reg  [1:0]    state_q;
  reg  [1:0]    state_d;
  reg  [CW-1:0] settle_cnt_q;
  reg  [CW-1:0] settle_cnt_d;
  reg           restart_d;             // One-cycle restart request

  // Pin differs from what we drive, so another party overrides it
  wire color_mis  = (color_s  != color_drv_q[1]);
  wire invert_mis = (invert_s != invert_drv_q[1]);

  // Pulse on polarity pin ended: mismatch gone after a short excursion
  wire pulse_end  = invert_ovr_q & ~invert_mis;
  wire pulse_ok   = (pulse_cnt_q <= PULSE_MAX_CYC[CW-1:0]);

  wire reacq      = pulse_end & pulse_ok & ~sersel_s;

  // Drive the indicator pins from detection
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      color_out_q  <= `VQ_RST_COLOR;
      invert_out_q <= `VQ_RST_INVERT;
      color_oe_q   <= 1'b0;
      invert_oe_q  <= 1'b0;
      color_drv_q  <= 2'h0;
      invert_drv_q <= 2'h0;
    end else begin
      color_oe_q   <= 1'b1;
      invert_oe_q  <= 1'b1;
      color_out_q  <= burst_s;
      // report detected polarity, high means inverted
      invert_out_q <= poldet_s;
      // Track our drive through the pin round trip
      color_drv_q  <= {color_drv_q[0], color_out_q};
      invert_drv_q <= {invert_drv_q[0], invert_out_q};
    end
  end

  // Override detection and pulse measurement
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      color_ovr_q  <= 1'b0;
      invert_ovr_q <= 1'b0;
      pulse_cnt_q  <= {CW{1'b0}};
    end else begin
      color_ovr_q  <= color_mis;
      invert_ovr_q <= invert_mis;
      pulse_cnt_q  <= pulse_cnt_d;
    end
  end

  // Pulse width counts while the pin is overridden
  always @* begin
    if (invert_mis) begin
      pulse_cnt_d = vq_inc(pulse_cnt_q);
    end else begin
      pulse_cnt_d = {CW{1'b0}};
    end
  end

  // Resolved pin levels set the signal chain mode
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      color_mode_q   <= 1'b0;
      video_invert_q <= 1'b0;
      eq_bypass_q    <= 1'b0;
    end else begin
      color_mode_q   <= color_s;
      video_invert_q <= invert_s;
      eq_bypass_q    <= bypass_s;
    end
  end

  // Next state of the equalizer sequence
  always @* begin
    state_d      = state_q;
    settle_cnt_d = settle_cnt_q;
    restart_d    = 1'b0;
    if (bypass_s) begin
      // Bypass parks the equalizer and drops lock
      state_d      = `VQ_ST_IDLE;
      settle_cnt_d = {CW{1'b0}};
    end else if (reacq) begin
      // Reacquire wins over freeze so a locked board can recover
      state_d      = `VQ_ST_ACQ;
      settle_cnt_d = {CW{1'b0}};
      restart_d    = 1'b1;
    end else if (freeze_s) begin
      state_d      = state_q;
      settle_cnt_d = settle_cnt_q;
    end else begin
      case (state_q)
        `VQ_ST_IDLE: begin
          // Wait for a signal, then start adapting
          if (sigpres_s) begin
            state_d   = `VQ_ST_ACQ;
            restart_d = 1'b1;
          end
        end
        `VQ_ST_ACQ: begin
          // Adapt until the analog loop reports settled
          settle_cnt_d = {CW{1'b0}};
          if (!sigpres_s) begin
            state_d = `VQ_ST_IDLE;
          end else if (settled_s) begin
            state_d = `VQ_ST_SETTLE;
          end
        end
        `VQ_ST_SETTLE: begin
          if (!sigpres_s) begin
            state_d      = `VQ_ST_IDLE;
            settle_cnt_d = {CW{1'b0}};
          end else if (!settled_s) begin
            state_d      = `VQ_ST_ACQ;
            settle_cnt_d = {CW{1'b0}};
          end else if (settle_cnt_q >= SETTLE_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
            state_d      = `VQ_ST_LOCK;
          end else begin
            settle_cnt_d = vq_inc(settle_cnt_q);
          end
        end
        `VQ_ST_LOCK: begin
          if (!sigpres_s) begin
            state_d = `VQ_ST_IDLE;
          end else if (!settled_s) begin
            state_d = `VQ_ST_ACQ;
          end
        end
        default: begin
          state_d = `VQ_ST_IDLE;
        end
      endcase
    end
  end

  // Equalizer state registers and outputs
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q        <= `VQ_ST_IDLE;
      settle_cnt_q   <= {CW{1'b0}};
      locked_q       <= `VQ_RST_LOCKED;
      eq_update_en_q <= 1'b0;
      eq_restart_q   <= 1'b0;
    end else begin
      state_q        <= state_d;
      settle_cnt_q   <= settle_cnt_d;
      locked_q       <= (state_d == `VQ_ST_LOCK);
      eq_update_en_q <= (state_d != `VQ_ST_IDLE) & ~freeze_s & ~bypass_s;
      eq_restart_q   <= restart_d;
    end
  end

endmodule

// ### design/vqctl_consts.vh
// Constants for the video equalizer control pin logic
`ifndef VQCTL_CONSTS_VH
`define VQCTL_CONSTS_VH

// Clock rate in MHz (50 MHz, 20 ns period)
`define VQ_CLK_MHZ          50
// Least time the equalizer must report settled before lock, in microseconds
`define VQ_SETTLE_TIME_US   20
// Longest override pulse that counts as a reacquire toggle, in microseconds
`define VQ_PULSE_MAX_US     1000
// Synchroniser depth for pin inputs
`define VQ_SYNC_STAGES      2

// Positions of the inputs inside the synchronised vector
`define VQ_SB_COLOR         0
`define VQ_SB_INVERT        1
`define VQ_SB_FREEZE        2
`define VQ_SB_BYPASS        3
`define VQ_SB_SERSEL        4
`define VQ_SB_BURST         5
`define VQ_SB_POLDET        6
`define VQ_SB_SIGPRES       7
`define VQ_SB_SETTLED       8
`define VQ_SB_WIDTH         9

// Equalizer state codes
`define VQ_ST_IDLE          2'h0
`define VQ_ST_ACQ           2'h1
`define VQ_ST_SETTLE        2'h2
`define VQ_ST_LOCK          2'h3

// Reset values of the indicator pins
`define VQ_RST_COLOR        1'h0
`define VQ_RST_INVERT       1'h0
`define VQ_RST_LOCKED       1'h0

`endif

// ### design/vqctl_sync.v
// Two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module vqctl_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         arst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  // First stage, read only by the second stage
  reg [W-1:0] meta_q;

  // Two stages on the system clock
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ### test/vqctl_board.sv
// Board model that resolves an indicator/override pin
`timescale 1ns/1ps
module vqctl_board (
  input  wire mclk,
  input  wire ovr_en,
  input  wire ovr_val,
  input  wire drv_oe,
  input  wire drv_val,
  output wire pin
);
  reg last_q = 1'h0; // Last level, for a floating pin
  always @(posedge mclk) last_q <= pin;
  assign pin = ovr_en ? ovr_val : (drv_oe ? drv_val : ~last_q);
endmodule

// ### test/vqctl_sva.sv
// Port checker for the control pin block
`timescale 1ns/1ps
module vqctl_sva (
  input wire mclk,
  input wire arst_n,
  input wire color_in,
  input wire invert_in,
  input wire freeze_in,
  input wire equalizer_bypass_ctl,
  input wire burst_det,
  input wire pol_det,
  input wire eq_settled,
  input wire color_out_q,
  input wire invert_out_q,
  input wire locked_q,
  input wire eq_update_en_q,
  input wire eq_restart_q,
  input wire eq_bypass_q,
  input wire color_mode_q,
  input wire video_invert_q,
  input wire color_ovr_q,
  input wire invert_ovr_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_cout; $past(arst_n, 3) |-> color_out_q == $past(burst_det, 3); endproperty
  a_cout: assert property (p_cout) else $error("color drive");
  property p_iout; $past(arst_n, 3) |-> invert_out_q == $past(pol_det, 3); endproperty
  a_iout: assert property (p_iout) else $error("polarity drive");
  property p_cmode; $past(arst_n, 3) |-> color_mode_q == $past(color_in, 3); endproperty
  a_cmode: assert property (p_cmode) else $error("color mode");
  property p_vinv; $past(arst_n, 3) |-> video_invert_q == $past(invert_in, 3); endproperty
  a_vinv: assert property (p_vinv) else $error("video invert");
  property p_byp; eq_bypass_q [*3] |-> !locked_q && !eq_update_en_q; endproperty
  a_byp: assert property (p_byp) else $error("bypass");
  property p_lock; $rose(locked_q) |-> $past(eq_settled, 4); endproperty
  a_lock: assert property (p_lock) else $error("lock early");
  property p_rst; eq_restart_q |-> !locked_q ##1 !eq_restart_q; endproperty
  a_rst: assert property (p_rst) else $error("restart");
  property p_frz;
    (freeze_in && !equalizer_bypass_ctl) [*6] |->
      !eq_update_en_q && ($stable(locked_q) || eq_restart_q);
  endproperty
  a_frz: assert property (p_frz) else $error("freeze");
  property p_covr;
    $past(arst_n, 3) |-> color_ovr_q == ($past(color_in, 3) != $past(color_out_q, 3));
  endproperty
  a_covr: assert property (p_covr) else $error("color override");
  property p_iovr;
    $past(arst_n, 3) |-> invert_ovr_q == ($past(invert_in, 3) != $past(invert_out_q, 3));
  endproperty
  a_iovr: assert property (p_iovr) else $error("polarity override");
  c_lock: cover property ($rose(locked_q));
  c_rst: cover property (eq_restart_q);
  c_frz: cover property (freeze_in [*6]);
endmodule

// ### test/vqctl_test.sv
// Self-checking bench for the control pin block
`timescale 1ns/1ps
module vqctl_test;
  logic mclk = 0, arst_n = 0, burst = 0, pol = 0, sig = 0, stl = 0;
  logic c_en = 0, c_val = 0, i_en = 0, i_val = 0, frz = 0, byp = 0, ssel = 1;
  wire c_pin, i_pin, c_out, c_oe, i_out, i_oe, lck, upd, rst, ebp, cmd, vinv;
  integer failures = 0, n_compared = 0, cyc = 0, i;
  logic [4:0] h[$]; // Pin history, oldest first
  vqctl_top #(.PULSE_MAX_CYC(20), .SETTLE_CYC(4)) dut (.mclk(mclk), .arst_n(arst_n),
    .color_in(c_pin), .color_out_q(c_out), .color_oe_q(c_oe), .invert_in(i_pin),
    .invert_out_q(i_out), .invert_oe_q(i_oe), .locked_q(lck), .freeze_in(frz),
    .equalizer_bypass_ctl(byp), .serial_select(ssel), .burst_det(burst),
    .pol_det(pol), .sig_present(sig), .eq_settled(stl), .eq_update_en_q(upd),
    .eq_restart_q(rst), .eq_bypass_q(ebp), .color_mode_q(cmd),
    .video_invert_q(vinv), .color_ovr_q(), .invert_ovr_q());
  vqctl_board u_cb (.mclk(mclk), .ovr_en(c_en), .ovr_val(c_val), .drv_oe(c_oe),
    .drv_val(c_out), .pin(c_pin));
  vqctl_board u_ib (.mclk(mclk), .ovr_en(i_en), .ovr_val(i_val), .drv_oe(i_oe),
    .drv_val(i_out), .pin(i_pin));
  initial forever #10 mclk = ~mclk;
  task chk(input string nm, input logic [4:0] s, input logic [4:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task step(input integer n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // Model: pin-derived outputs lag the inputs by two sampled edges
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      test_done;
    end
    if (!arst_n) h = {};
    else h.push_back({burst, pol, c_pin, i_pin, byp});
    if (h.size() > 3) void'(h.pop_front());
  end
  always @(negedge mclk) if (h.size() == 3)
    chk("pins", {c_out, i_out, cmd, vinv, ebp}, h[0]);
  initial begin
    void'($urandom(22));
    step(20);
    arst_n = 1;
    for (i = 0; i < 80; i++) begin
      {burst, pol, c_en, c_val, i_en, i_val, byp} = 7'($urandom);
      step(1);
    end
    {c_en, i_en, byp, pol} = 4'h0;
    sig = 1;
    stl = 1;
    for (i = 0; i < 40 && lck !== 1'b1; i++) step(1);
    chk("lock", {4'h0, lck}, 5'h01);
    for (i = 0; i < 14; i++) begin
      frz = lck;
      if (i == 4) {sig, stl} = 2'h0;
      step(1);
    end
    chk("frozen", {3'h0, lck, upd}, 5'h02);
    {sig, stl, ssel, i_en} = 4'hD;
    i_val = ~i_out;
    step(4);
    i_en = 0;
    for (i = 0; i < 12 && rst !== 1'b1; i++) step(1);
    chk("restart", {3'h0, rst, lck}, 5'h02);
    for (i = 0; i < 40 && lck !== 1'b1; i++) begin
      frz = lck;
      step(1);
    end
    chk("relock", {3'h0, lck, upd}, 5'h03);
    {frz, ssel, i_en} = 3'h3;
    i_val = ~i_out;
    step(4);
    i_en = 0;
    for (i = 0; i < 12 && rst !== 1'b1; i++) step(1);
    chk("no_restart", {3'h0, rst, lck}, 5'h01);
    byp = 1;
    step(6);
    chk("bypass", {3'h0, lck, upd}, 5'h00);
    byp = 0;
    step(40);
    test_done;
  end
endmodule
bind vqctl_top vqctl_sva u_sva (.*);
